// >>> logic/dpll_ref_pkg.sv
package dpll_ref_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] REFSEL_OFS = 8'h04;
   localparam logic [7:0] PRI_DIV_OFS = 8'h08;
   localparam logic [7:0] SEC_DIV_OFS = 8'h0C;
   localparam logic [7:0] TRIM_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;

   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PREF_BIT = 2;
   localparam int CTRL_OP_LSB = 3;
   localparam int CTRL_RATE_BIT = 5;
   localparam int REFSEL_PRI_LSB = 0;
   localparam int REFSEL_SEC_LSB = 4;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_ACTIVE_BIT = 2;
   localparam int STAT_PRI_FAIL_BIT = 3;
   localparam int STAT_SEC_FAIL_BIT = 4;

   // Reference selection and division
   localparam int NUM_STREAMS = 4;
   localparam int SRC_W = 3;
   localparam logic [2:0] SRC_EXT_PIN = 3'h4;
   localparam int DIV_W = 12;
   localparam logic [11:0] DIV_RESET = 12'h001;
   localparam logic [11:0] DIV_PASS = 12'h001;
   localparam logic [11:0] DIV_22M368_TO_8K = 12'hAEC;
   localparam logic [11:0] DIV_34M368_TO_64K = 12'h219;
   localparam logic [11:0] DIV_44M736_TO_64K = 12'h2BB;

   // Timing
   localparam longint CLK_FREQ_HZ = 20000000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int REF_LOSS_TIME_NS = 250000;
   localparam int REF_LOSS_CYCLES = REF_LOSS_TIME_NS / CLK_PERIOD_NS;
   localparam longint X2_RATE_LOW_HZ = 4096000;
   localparam longint X2_RATE_HIGH_HZ = 16384000;
   localparam longint FRAME_HZ = 8000;
   localparam logic [31:0] NCO_INC_LOW = 32'((X2_RATE_LOW_HZ << 32) / CLK_FREQ_HZ);
   localparam logic [31:0] NCO_INC_HIGH = 32'((X2_RATE_HIGH_HZ << 32) / CLK_FREQ_HZ);
   localparam logic [10:0] FRAME_CNT_LOW = 11'(X2_RATE_LOW_HZ / FRAME_HZ - 1);
   localparam logic [10:0] FRAME_CNT_HIGH = 11'(X2_RATE_HIGH_HZ / FRAME_HZ - 1);

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_LOCKING = 2'b00,
      MODE_HOLDOVER = 2'b01,
      MODE_FREERUN = 2'b10,
      MODE_POWERDOWN = 2'b11
   } pllMode_e;

   typedef enum logic [1:0] {
      OP_MASTER = 2'b00,
      OP_SLAVE = 2'b01,
      OP_UNSTRUCT = 2'b10
   } operation_e;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axiReq_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } axiRsp_s;

endpackage

// >>> logic/dpll_reference_input_select.sv
`timescale 1ns/100ps
// Summary of operation
// - The loop is always in exactly one of locking, holdover, freerun or powerdown mode.
// - In locking mode the loop follows the primary or the secondary reference, the other standing by as backup.
// - Each reference is chosen from any of the four stream clocks or from its own external reference pin.
// - A divider value of one passes the reference undivided to the loop input.
// - Divider values AEC, 219 and 2BB divide the reference by that count.
// - As structured timing master the loop drives the clock and frame references for the TDM side.
// - As structured slave the loop is unused and the TDM interface resynchronises the input streams.
// - In unstructured operation the loop is unavailable and per-stream oscillators time each stream.
// - A divider value of zero blocks its reference completely.
// - With both references failed, locking falls back to holdover and keeps the last frequency.
// - The loop outputs a common clock, a double-rate common clock and an 8 kHz frame reference.
// - The common clock runs at 2.048 or 8.192 Mbps by a control bit, the double clock at twice that only at 2.048 Mbps.
module dpll_reference_input_select #(
   parameter int REF_LOSS_LIMIT = dpll_ref_pkg::REF_LOSS_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire dpll_ref_pkg::axiReq_s axiReq,
   output dpll_ref_pkg::axiRsp_s axiRsp,
   input wire logic [dpll_ref_pkg::NUM_STREAMS-1:0] tdmStreamClk,
   input wire logic extPrimaryRefPin,
   input wire logic extSecondaryRefPin,
   output logic dividedPrimaryRef,
   output logic dividedSecondaryRef,
   output logic loopReference,
   output logic sharedTdmClock,
   output logic sharedTdmClockDouble,
   output logic frameRef8k,
   output logic tdmInputResync,
   output logic streamNcoEnable
);
   import dpll_ref_pkg::*;

   if (REF_LOSS_LIMIT < 1 || REF_LOSS_LIMIT > 65534) begin : g_bad_limit
      $error("REF_LOSS_LIMIT out of range for the 16-bit loss counter");
   end

   localparam logic [15:0] LOSS_LIMIT = 16'(REF_LOSS_LIMIT);

   typedef struct packed {
      axiRsp_s rsp;
      logic awGot;
      logic wGot;
      logic [ADDR_W-1:0] awAddr;
      logic [DATA_W-1:0] wData;
      logic [3:0] wStrb;
      pllMode_e reqMode;
      logic prefSec;
      operation_e op;
      logic rateHigh;
      logic [1:0][SRC_W-1:0] srcSel;
      logic [1:0][DIV_W-1:0] div;
      logic [31:0] trim;
      logic [1:0] refPrev;
      logic [1:0][DIV_W-1:0] cnt;
      logic [1:0] divOut;
      logic [1:0][15:0] lossCnt;
      logic [1:0] fail;
      pllMode_e mode;
      logic activeSec;
      logic loopRef;
      logic [31:0] freqWord;
      logic [31:0] phase;
      logic [10:0] frameCnt;
      logic comClk;
      logic shared_tdm_clock_double;
      logic frame;
      logic resyncEn;
      logic streamNcoEn;
   } state_s;

   function automatic state_s resetState();
      state_s r;
      r = '0;
      r.rsp.awready = 1'b1;
      r.rsp.wready = 1'b1;
      r.rsp.arready = 1'b1;
      r.reqMode = MODE_FREERUN;
      r.op = OP_MASTER;
      r.mode = MODE_FREERUN;
      r.div[0] = DIV_RESET;
      r.div[1] = DIV_RESET;
      r.srcSel[0] = SRC_EXT_PIN;
      r.srcSel[1] = SRC_EXT_PIN;
      r.freqWord = NCO_INC_LOW;
      return r;
   endfunction

   localparam state_s RESET_STATE = resetState();

   // Stream clocks 0..3, or the path's own pin; other codes select nothing
   function automatic logic selectRef(input logic [SRC_W-1:0] sel, input logic [NUM_STREAMS-1:0] streams,
                                      input logic pin);
      logic v;
      v = 1'b0;
      if (sel < SRC_W'(NUM_STREAMS)) begin
         v = streams[sel[1:0]];
      end else if (sel == SRC_EXT_PIN) begin
         v = pin;
      end
      return v;
   endfunction

   // Returns {resp, data}; unmapped words answer SLVERR with zero data
   function automatic logic [33:0] regRead(input state_s s, input logic [ADDR_W-1:0] addr);
      logic [31:0] d;
      logic [1:0] resp;
      d = '0;
      resp = RESP_OKAY;
      case ({addr[ADDR_W-1:2], 2'b00})
         CTRL_OFS: begin
            d[CTRL_MODE_LSB +: 2] = s.reqMode;
            d[CTRL_PREF_BIT] = s.prefSec;
            d[CTRL_OP_LSB +: 2] = s.op;
            d[CTRL_RATE_BIT] = s.rateHigh;
         end
         REFSEL_OFS: begin
            d[REFSEL_PRI_LSB +: SRC_W] = s.srcSel[0];
            d[REFSEL_SEC_LSB +: SRC_W] = s.srcSel[1];
         end
         PRI_DIV_OFS: d[DIV_W-1:0] = s.div[0];
         SEC_DIV_OFS: d[DIV_W-1:0] = s.div[1];
         TRIM_OFS: d = s.trim;
         STATUS_OFS: begin
            d[STAT_MODE_LSB +: 2] = s.mode;
            d[STAT_ACTIVE_BIT] = s.activeSec;
            d[STAT_PRI_FAIL_BIT] = s.fail[0];
            d[STAT_SEC_FAIL_BIT] = s.fail[1];
         end
         default: resp = RESP_SLVERR;
      endcase
      return {resp, d};
   endfunction

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[8*b +: 8] = wr[8*b +: 8];
         end
      end
      return m;
   endfunction

   state_s s;
   state_s next_s;

   always_comb begin
      logic [33:0] rd;
      logic [31:0] v;
      logic [1:0] lvl;
      logic [1:0] rise;
      logic pref;
      logic run;
      logic [31:0] nominal;
      logic [10:0] frameTop;
      logic carry;
      rd = '0;
      v = '0;
      lvl = '0;
      rise = '0;
      pref = s.prefSec;
      run = 1'b0;
      nominal = s.rateHigh ? NCO_INC_HIGH : NCO_INC_LOW;
      frameTop = s.rateHigh ? FRAME_CNT_HIGH : FRAME_CNT_LOW;
      carry = 1'b0;
      next_s = s;

      // Bus write: address and data are taken in either order
      if (axiReq.awvalid && s.rsp.awready) begin
         next_s.awGot = 1'b1;
         next_s.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && s.rsp.wready) begin
         next_s.wGot = 1'b1;
         next_s.wData = axiReq.wdata;
         next_s.wStrb = axiReq.wstrb;
      end
      if (s.rsp.bvalid && axiReq.bready) begin
         next_s.rsp.bvalid = 1'b0;
      end
      if (s.awGot && s.wGot && !s.rsp.bvalid) begin
         rd = regRead(s, s.awAddr);
         v = mergeBytes(rd[31:0], s.wData, s.wStrb);
         next_s.awGot = 1'b0;
         next_s.wGot = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp = rd[33:32];
         case ({s.awAddr[ADDR_W-1:2], 2'b00})
            CTRL_OFS: begin
               next_s.reqMode = pllMode_e'(v[CTRL_MODE_LSB +: 2]);
               next_s.prefSec = v[CTRL_PREF_BIT];
               // Reserved operation code is ignored rather than stored
               if (v[CTRL_OP_LSB +: 2] != 2'b11) begin
                  next_s.op = operation_e'(v[CTRL_OP_LSB +: 2]);
               end
               next_s.rateHigh = v[CTRL_RATE_BIT];
            end
            REFSEL_OFS: begin
               next_s.srcSel[0] = v[REFSEL_PRI_LSB +: SRC_W];
               next_s.srcSel[1] = v[REFSEL_SEC_LSB +: SRC_W];
            end
            PRI_DIV_OFS: next_s.div[0] = v[DIV_W-1:0];
            SEC_DIV_OFS: next_s.div[1] = v[DIV_W-1:0];
            TRIM_OFS: next_s.trim = v;
            default: next_s.trim = s.trim;
         endcase
      end
      next_s.rsp.awready = !next_s.awGot && !next_s.rsp.bvalid;
      next_s.rsp.wready = !next_s.wGot && !next_s.rsp.bvalid;

      // Bus read
      if (s.rsp.rvalid && axiReq.rready) begin
         next_s.rsp.rvalid = 1'b0;
      end
      if (axiReq.arvalid && s.rsp.arready) begin
         rd = regRead(s, axiReq.araddr);
         next_s.rsp.rvalid = 1'b1;
         next_s.rsp.rdata = rd[31:0];
         next_s.rsp.rresp = rd[33:32];
      end
      next_s.rsp.arready = !next_s.rsp.rvalid;

      // Reference paths: selector, divider and activity monitor
      lvl[0] = selectRef(s.srcSel[0], tdmStreamClk, extPrimaryRefPin);
      lvl[1] = selectRef(s.srcSel[1], tdmStreamClk, extSecondaryRefPin);
      for (int i = 0; i < 2; i++) begin
         rise[i] = lvl[i] && !s.refPrev[i];
         next_s.refPrev[i] = lvl[i];
         if (s.div[i] == '0) begin
            next_s.cnt[i] = '0;
         end else if (rise[i]) begin
            // Count wraps after div input cycles; a shrunk divider wraps at once
            next_s.cnt[i] = (s.cnt[i] >= s.div[i] - DIV_PASS) ? '0 : s.cnt[i] + DIV_PASS;
         end
         // With div of one the count stays zero and the input passes through
         next_s.divOut[i] = (s.div[i] != '0) && lvl[i] && (next_s.cnt[i] == '0);
         if (next_s.divOut[i] && !s.divOut[i]) begin
            next_s.lossCnt[i] = '0;
         end else if (s.lossCnt[i] != 16'hFFFF) begin
            next_s.lossCnt[i] = s.lossCnt[i] + 16'h0001;
         end
         next_s.fail[i] = next_s.lossCnt[i] >= LOSS_LIMIT;
      end

      // Mode and active reference
      next_s.activeSec = s.activeSec;
      case (s.reqMode)
         MODE_LOCKING: begin
            if (s.fail[0] && s.fail[1]) begin
               next_s.mode = MODE_HOLDOVER;
            end else begin
               next_s.mode = MODE_LOCKING;
               next_s.activeSec = s.fail[pref] ? !pref : pref;
            end
         end
         default: next_s.mode = s.reqMode;
      endcase
      // Only a timing master feeds the loop; slave and unstructured ports leave it idle
      next_s.loopRef = (next_s.mode == MODE_LOCKING) && (s.op == OP_MASTER) &&
                       (next_s.activeSec ? next_s.divOut[1] : next_s.divOut[0]);

      // Loop oscillator; the tracking correction arrives as the software trim
      case (next_s.mode)
         MODE_LOCKING: next_s.freqWord = nominal + s.trim;
         MODE_FREERUN: next_s.freqWord = nominal;
         default: next_s.freqWord = s.freqWord;
      endcase
      run = (next_s.mode != MODE_POWERDOWN) && (s.op == OP_MASTER);
      if (run) begin
         {carry, next_s.phase} = {1'b0, s.phase} + {1'b0, next_s.freqWord};
         // Above half the clock rate the msb aliases, so accumulator wraps pace the common clock and frame
         next_s.shared_tdm_clock_double = next_s.phase[31];
         if (carry) begin
            next_s.comClk = !s.comClk;
            next_s.frameCnt = (s.frameCnt >= frameTop) ? '0 : s.frameCnt + 11'h001;
            next_s.frame = (next_s.frameCnt == '0);
         end
      end else begin
         // Outputs are parked low so a slave or unstructured port sees no stray edges
         next_s.phase = '0;
         next_s.shared_tdm_clock_double = 1'b0;
         next_s.comClk = 1'b0;
         next_s.frameCnt = '0;
         next_s.frame = 1'b0;
      end
      next_s.resyncEn = (s.op == OP_SLAVE);
      next_s.streamNcoEn = (s.op == OP_UNSTRUCT);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   assign axiRsp = s.rsp;
   assign dividedPrimaryRef = s.divOut[0];
   assign dividedSecondaryRef = s.divOut[1];
   assign loopReference = s.loopRef;
   assign sharedTdmClock = s.comClk;
   assign sharedTdmClockDouble = s.shared_tdm_clock_double;
   assign frameRef8k = s.frame;
   assign tdmInputResync = s.resyncEn;
   assign streamNcoEnable = s.streamNcoEn;

endmodule

// >>> tb/dpll_ref_properties.sv
`timescale 1ns/100ps
module dpll_ref_properties #(
   parameter int REF_LOSS_LIMIT = 50
) (
   input wire logic clk,
   input wire logic nrst,
   input wire dpll_ref_pkg::axiReq_s axiReq,
   input wire dpll_ref_pkg::axiRsp_s axiRsp,
   input wire logic loopReference,
   input wire logic sharedTdmClockDouble,
   input wire logic frameRef8k,
   input wire logic tdmInputResync,
   input wire logic streamNcoEnable
);
   import dpll_ref_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_read_latency: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
      else $error("read answer late");
   a_write_latency: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
      |-> ##[1:2] axiRsp.bvalid) else $error("write answer late");
   a_b_release: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
      else $error("bvalid kept after accept");
   a_r_release: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
      else $error("rvalid kept after accept");
   a_aw_blocked: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
      else $error("write taken while response pending");
   a_ar_blocked: assert property (axiRsp.rvalid |-> !axiRsp.arready)
      else $error("read taken while data pending");
   a_slave_park: assert property (tdmInputResync [*2] |-> !sharedTdmClockDouble && !frameRef8k && !streamNcoEnable)
      else $error("loop active in slave operation");
   a_nco_park: assert property (streamNcoEnable [*2] |-> !sharedTdmClockDouble && !frameRef8k && !loopReference)
      else $error("loop active in unstructured operation");
   a_double_high: assert property ($rose(sharedTdmClockDouble) |-> ##[1:3] !sharedTdmClockDouble)
      else $error("double clock high too long");
   a_frame_width: assert property ($rose(frameRef8k) |-> ##[1:6] !frameRef8k)
      else $error("frame reference too wide");
   cover property (axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR);
   cover property ($rose(frameRef8k));
   cover property ($rose(tdmInputResync));
endmodule
bind dpll_reference_input_select dpll_ref_properties #(.REF_LOSS_LIMIT(REF_LOSS_LIMIT)) u_props (.clk, .nrst,
   .axiReq, .axiRsp, .loopReference, .sharedTdmClockDouble, .frameRef8k, .tdmInputResync, .streamNcoEnable);

// >>> tb/ref_source_model.sv
`timescale 1ns/100ps
// Far-side reference sources: stream clocks and the two external pins
module ref_source_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [5:0] runEn,
   output logic [3:0] streamClk,
   output logic priPin,
   output logic secPin
);
   logic [7:0] cyc;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         cyc <= 8'h00;
      else
         cyc <= cyc + 8'h01;
   end
   // Stopped sources stand low, as a lost line would
   assign streamClk = {cyc[2], cyc[3], cyc[2], cyc[1]} & runEn[3:0];
   // Both pins share one nominal rate, period 4 clocks
   assign priPin = cyc[1] & runEn[4];
   assign secPin = cyc[1] & runEn[5];
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
   import dpll_ref_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   axiReq_s axiReq = '{wstrb: 4'hF, default: '0};
   axiRsp_s axiRsp;
   logic [3:0] streamClk;
   logic priPin, secPin, divPri, divSec, loopRef, comClk, dblClk, frame, resync, ncoEn;
   logic [5:0] runEn = 6'h3F;
   logic [5:0] prv = '0;
   logic [1:0] wq[$];
   logic [65:0] rq[$];
   logic [11:0] divs[5] = '{12'hAEC, 12'h219, 12'h2BB, 12'h000, 12'h001};
   logic [31:0] rnd;
   int num_errors = 0, samples_checked = 0, cyc = 0, seed = 88, d;
   int cPri, cSec, cDbl, cFrm, cLoop, cCom;
   always #25 clk = ~clk;
   dpll_reference_input_select #(.REF_LOSS_LIMIT(50)) u_dut (.clk(clk), .nrst(nrst), .axiReq(axiReq),
      .axiRsp(axiRsp), .tdmStreamClk(streamClk), .extPrimaryRefPin(priPin), .extSecondaryRefPin(secPin),
      .dividedPrimaryRef(divPri), .dividedSecondaryRef(divSec), .loopReference(loopRef),
      .sharedTdmClock(comClk), .sharedTdmClockDouble(dblClk), .frameRef8k(frame),
      .tdmInputResync(resync), .streamNcoEnable(ncoEn));
   ref_source_model u_src (.clk(clk), .nrst(nrst), .runEn(runEn), .streamClk(streamClk),
      .priPin(priPin), .secPin(secPin));
   task automatic give_verdict();
      if (num_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic fail(logic [63:0] g, logic [63:0] e);
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
   endtask
   task automatic cmpW(logic [1:0] g, logic [1:0] e);
      samples_checked++;
      if (g !== e) fail(g, e);
   endtask
   task automatic cmpR(logic [1:0] r, logic [31:0] g, logic [65:0] e);
      samples_checked++;
      if (r !== e[65:64] || (g & e[63:32]) !== e[31:0]) fail({r, g}, {e[65:64], e[31:0]});
   endtask
   task automatic cmpN(int g, int lo, int hi);
      samples_checked++;
      if (g < lo || g > hi) fail(g, lo);
   endtask
   task automatic cmpF(logic g, logic e);
      samples_checked++;
      if (g !== e) fail(g, e);
   endtask
   // Edge counters and the response watcher
   always @(posedge clk) begin
      prv <= {comClk, loopRef, frame, dblClk, divSec, divPri};
      cCom += int'(comClk & ~prv[5]);
      cPri += int'(divPri & ~prv[0]);
      cSec += int'(divSec & ~prv[1]);
      cDbl += int'(dblClk & ~prv[2]);
      cFrm += int'(frame & ~prv[3]);
      cLoop += int'(loopRef & ~prv[4]);
      if (axiRsp.bvalid === 1'b1 && axiReq.bready) cmpW(axiRsp.bresp, wq.pop_front());
      if (axiRsp.rvalid === 1'b1 && axiReq.rready) cmpR(axiRsp.rresp, axiRsp.rdata, rq.pop_front());
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic wr(logic [7:0] a, logic [31:0] dt, logic [1:0] r = RESP_OKAY);
      wq.push_back(r);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= dt;
      axiReq.bready <= 1'b1;
      do begin
         @(posedge clk);
         if (axiRsp.awready) axiReq.awvalid <= 1'b0;
         if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      end while (axiRsp.bvalid !== 1'b1);
      axiReq.bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] r = RESP_OKAY);
      rq.push_back({r, m, e});
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      end while (axiRsp.rvalid !== 1'b1);
      axiReq.rready <= 1'b0;
      @(posedge clk);
   endtask
   // Counters restart here; a race with the watcher costs one edge at most
   task automatic meas(int n);
      cPri = 0;
      cSec = 0;
      cDbl = 0;
      cFrm = 0;
      cLoop = 0;
      cCom = 0;
      repeat (n) @(posedge clk);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(CTRL_OFS, '1, 32'h2);
      rd(REFSEL_OFS, '1, 32'h44);
      rd(PRI_DIV_OFS, '1, 32'h1);
      rd(SEC_DIV_OFS, '1, 32'h1);
      rd(TRIM_OFS, '1, 32'h0);
      rd(STATUS_OFS, 32'h3, 32'h2);
      rnd = $random(seed);
      wr(TRIM_OFS, rnd);
      rd(TRIM_OFS, '1, rnd);
      foreach (divs[i]) begin
         wr(PRI_DIV_OFS, {20'h0, divs[i]});
         wr(SEC_DIV_OFS, {20'h0, divs[4 - i]});
         rd(PRI_DIV_OFS, '1, {20'h0, divs[i]});
         rd(SEC_DIV_OFS, '1, {20'h0, divs[4 - i]});
      end
      wr(8'h18, rnd, RESP_SLVERR);
      rd(8'h18, '1, 32'h0, RESP_SLVERR);
      wr(STATUS_OFS, '1);
      rd(STATUS_OFS, 32'h3, 32'h2);
      wr(CTRL_OFS, 32'h1A);
      rd(CTRL_OFS, '1, 32'h2);
      d = 2 + int'($unsigned($random(seed)) % 6);
      wr(REFSEL_OFS, 32'h42);
      wr(PRI_DIV_OFS, 32'h1);
      wr(SEC_DIV_OFS, d);
      meas(400);
      cmpN(cPri, 24, 26);
      cmpN(cSec, 100 / d - 1, 100 / d + 1);
      wr(SEC_DIV_OFS, {20'h0, DIV_34M368_TO_64K});
      meas(4400);
      cmpN(cSec, 4400 / (4 * 12'h219), 4400 / (4 * 12'h219));
      wr(SEC_DIV_OFS, d);
      wr(PRI_DIV_OFS, 32'h0);
      meas(100);
      cmpN(cPri, 0, 0);
      rd(STATUS_OFS, 32'h8, 32'h8);
      wr(CTRL_OFS, 32'h0);
      rd(STATUS_OFS, 32'h7, 32'h4);
      wr(PRI_DIV_OFS, 32'h1);
      meas(100);
      rd(STATUS_OFS, 32'h7, 32'h0);
      meas(160);
      cmpN(cLoop, 9, 11);
      wr(CTRL_OFS, 32'h4);
      rd(STATUS_OFS, 32'h7, 32'h4);
      runEn <= 6'h00;
      meas(200);
      rd(STATUS_OFS, 32'h1B, 32'h19);
      meas(100);
      cmpN(cLoop, 0, 0);
      runEn <= 6'h3F;
      meas(100);
      rd(STATUS_OFS, 32'h3, 32'h0);
      wr(CTRL_OFS, 32'h02);
      meas(1000);
      cmpN(cDbl, 203, 207);
      cmpN(cCom, 101, 104);
      wr(CTRL_OFS, 32'h22);
      meas(5000);
      cmpN(cCom, 2046, 2050);
      cmpN(cFrm, 1, 3);
      wr(CTRL_OFS, 32'h0A);
      meas(200);
      cmpN(cDbl, 0, 0);
      cmpF(resync, 1'b1);
      wr(CTRL_OFS, 32'h12);
      meas(200);
      cmpN(cFrm, 0, 0);
      cmpF(ncoEn, 1'b1);
      cmpF(resync, 1'b0);
      wr(CTRL_OFS, 32'h03);
      meas(200);
      cmpN(cDbl, 0, 0);
      give_verdict();
   end
endmodule
